/* File: hw/fixmap_defs.svh */
`ifndef FIXMAP_DEFS_SVH
`define FIXMAP_DEFS_SVH

// virtual segments, 512 Mbytes each
`define SEG_A_TOP        3'h4
`define SEG_B_TOP        3'h5
`define SEG_OFFS_MASK    32'h1fff_ffff

// physical regions, inclusive bounds
`define PROG_FIRST       32'h1d00_0000
`define PROG_LAST        32'h1d03_ffff
`define RAM_FIRST        32'h0000_0000
`define RAM_LAST         32'h0000_7fff
`define BOOT_FIRST       32'h1fc0_0000
`define BOOT_LAST        32'h1fc0_17ff
`define SFR_FIRST        32'h1f80_0000
`define SFR_LAST         32'h1f80_ffff

// configuration word areas
`define CFG_PRI_FIRST    32'h1fc0_1780
`define CFG_PRI_LAST     32'h1fc0_17e8
`define CFG_ALT_FIRST    32'h1fc0_1700
`define CFG_ALT_LAST     32'h1fc0_1768
`define CFG_STEP         32'h0000_0004
`define CFG_DEFAULT_WORD 32'hffff_ffff

// reset status flag positions
`define RSTAT_PRI_ERR_BIT 27
`define RSTAT_FAIL_BIT    26

// core feature register, coprocessor register 16 select 5
`define CFG5_REG_NUM     5'h10
`define CFG5_SEL         3'h5
`define CFG5_RESET       32'h0000_0001

`endif

/* File: hw/fixmap_pkg.sv */
`include "fixmap_defs.svh"

package fixmap_pkg;

	typedef enum logic [2:0] {
		REG_NONE = 3'b000,
		REG_PROG = 3'b001,
		REG_RAM  = 3'b010,
		REG_BOOT = 3'b011,
		REG_SFR  = 3'b100
	} region_t;

	typedef enum logic [1:0] {
		LD_PRI  = 2'b00,
		LD_ALT  = 2'b01,
		LD_DEF  = 2'b10,
		LD_DONE = 2'b11
	} loader_state_t;

	function automatic region_t region_of(input logic [31:0] paddr);
		if (paddr >= `PROG_FIRST && paddr <= `PROG_LAST) begin
			return REG_PROG;
		end else if (paddr <= `RAM_LAST) begin
			return REG_RAM;
		end else if (paddr >= `BOOT_FIRST && paddr <= `BOOT_LAST) begin
			return REG_BOOT;
		end else if (paddr >= `SFR_FIRST && paddr <= `SFR_LAST) begin
			return REG_SFR;
		end
		return REG_NONE;
	endfunction : region_of

endpackage : fixmap_pkg

/* File: hw/fixed_mapping_unit.sv */
`timescale 1ns/1ns
`include "fixmap_defs.svh"

module fixed_mapping_unit (
	// mode
	input  wire logic              bypass,
	input  wire logic              error_level_flag,
	input  wire logic              ram_exec_en,
	// access
	input  wire logic              fetch,
	input  wire logic [31:0]       vaddr,
	// result
	output logic [31:0]            paddr,
	output fixmap_pkg::region_t    region,
	output logic                   fault
);
	import fixmap_pkg::*;

	wire logic    seg_a      = (vaddr[31:29] == `SEG_A_TOP);  // [R3]
	wire logic    seg_b      = (vaddr[31:29] == `SEG_B_TOP);  // [R3]
	wire logic    phys_mode  = bypass | error_level_flag;  // [R7] [R8]
	wire logic [31:0] mapped = vaddr & `SEG_OFFS_MASK;  // [R5]
	wire region_t hit        = region_of(paddr);
	wire logic    low_region = (hit == REG_PROG) || (hit == REG_RAM);
	wire logic    reach_ok   = phys_mode ? (hit != REG_NONE) :
		seg_b ? (hit != REG_NONE) :
		seg_a ? low_region : 1'b0;  // [R4]
	wire logic    exec_bad   = fetch && (hit == REG_RAM) && !ram_exec_en;  // [R9]

	assign paddr  = phys_mode ? vaddr : mapped;  // [R7] [R8]
	assign region = reach_ok ? hit : REG_NONE;
	assign fault  = !reach_ok || exec_bad;

endmodule : fixed_mapping_unit

/* File: hw/addr_map_top.sv */
`timescale 1ns/1ns
`include "fixmap_defs.svh"
// Contract
// R1 - feature register bit zero reads one
// R2 - feature register bits above zero read zero
// R3 - two 512 Mbyte virtual segments mapped
// R4 - flash/ram both segments; boot, peripherals second only
// R5 - segments translate by fixed scheme
// R6 - reset, soft reset, NMI set error level
// R7 - error level: CPU addresses are physical
// R8 - other initiators present physical addresses
// R9 - fetch from data ram when executable
// R10 - primary ECC error: flag bit 27, use alternate
// R11 - both fail: flag bit 26, use defaults
// R12 - primary words at 0x1FC01780..0x1FC017E8
// R13 - alternate words at 0x1FC01700..0x1FC01768
// R14 - hold CPU reset until selection done

module addr_map_top #(
	parameter int NUM_WORDS = int'((`CFG_PRI_LAST - `CFG_PRI_FIRST) / `CFG_STEP) + 1
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// cpu side
	input  wire logic              cpu_req,
	input  wire logic              cpu_fetch,
	input  wire logic [31:0]       cpu_addr,
	input  wire logic              soft_reset,
	input  wire logic              nmi,
	input  wire logic              error_level_clear,
	input  wire logic              ram_exec_en,
	output logic [31:0]            cpu_paddr_ff,
	output fixmap_pkg::region_t    cpu_region_ff,
	output logic                   cpu_fault_ff,
	output logic                   cpu_ack_ff,
	output logic                   error_level_flag_ff,
	output logic                   cpu_reset_hold_ff,
	// other initiator
	input  wire logic              dma_req,
	input  wire logic [31:0]       dma_addr,
	output logic [31:0]            dma_paddr_ff,
	output fixmap_pkg::region_t    dma_region_ff,
	output logic                   dma_fault_ff,
	output logic                   dma_ack_ff,
	// coprocessor register read
	input  wire logic              cp0_rd_en,
	input  wire logic [4:0]        cp0_reg_num,
	input  wire logic [2:0]        cp0_sel,
	output logic [31:0]            cp0_rd_data_ff,
	output logic                   cp0_rd_valid_ff,
	// configuration word fetch
	output logic                   cfg_rd_req_ff,
	output logic [31:0]            cfg_rd_addr_ff,
	input  wire logic              cfg_rd_valid,
	input  wire logic [31:0]       cfg_rd_data,
	input  wire logic              cfg_rd_ecc_err,
	// loaded configuration
	input  wire logic [4:0]        cfg_word_idx,
	output logic [31:0]            cfg_word_ff,
	output logic [31:0]            reset_status_register_ff
);
	import fixmap_pkg::*;

	localparam logic [4:0] LAST_IDX = 5'(NUM_WORDS - 1);

	logic [1:0]          rst_sync_ff;
	wire logic           rst_sync_b = rst_sync_ff[1];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end

	// error level
	logic                nxt_error_level;
	assign nxt_error_level = (soft_reset || nmi) ? 1'b1 :
		(error_level_clear && !cpu_reset_hold_ff) ? 1'b0 : error_level_flag_ff;  // [R6]

	// translation
	logic [31:0]         cpu_paddr;
	region_t             cpu_region;
	logic                cpu_fault;
	logic [31:0]         dma_paddr;
	region_t             dma_region;
	logic                dma_fault;

	fixed_mapping_unit u_cpu_map (
		.bypass           (1'b0),
		.error_level_flag (error_level_flag_ff),
		.ram_exec_en      (ram_exec_en),
		.fetch            (cpu_fetch),
		.vaddr            (cpu_addr),
		.paddr            (cpu_paddr),
		.region           (cpu_region),
		.fault            (cpu_fault)
	);

	fixed_mapping_unit u_dma_map (
		.bypass           (1'b1),  // [R8]
		.error_level_flag (error_level_flag_ff),
		.ram_exec_en      (1'b0),
		.fetch            (1'b0),
		.vaddr            (dma_addr),
		.paddr            (dma_paddr),
		.region           (dma_region),
		.fault            (dma_fault)
	);

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cpu_paddr_ff        <= 32'h0;
			cpu_region_ff       <= REG_NONE;
			cpu_fault_ff        <= 1'b0;
			cpu_ack_ff          <= 1'b0;
			dma_paddr_ff        <= 32'h0;
			dma_region_ff       <= REG_NONE;
			dma_fault_ff        <= 1'b0;
			dma_ack_ff          <= 1'b0;
			error_level_flag_ff <= 1'b1;  // [R6]
		end else begin
			cpu_paddr_ff        <= cpu_paddr;
			cpu_region_ff       <= cpu_region;
			cpu_fault_ff        <= cpu_req && cpu_fault;
			cpu_ack_ff          <= cpu_req;
			dma_paddr_ff        <= dma_paddr;
			dma_region_ff       <= dma_region;
			dma_fault_ff        <= dma_req && dma_fault;
			dma_ack_ff          <= dma_req;
			error_level_flag_ff <= nxt_error_level;
		end
	end

	// feature register read
	wire logic cfg5_hit = (cp0_reg_num == `CFG5_REG_NUM) && (cp0_sel == `CFG5_SEL);

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cp0_rd_data_ff  <= 32'h0;
			cp0_rd_valid_ff <= 1'b0;
		end else begin
			cp0_rd_data_ff  <= (cp0_rd_en && cfg5_hit) ? `CFG5_RESET : 32'h0;  // [R1] [R2]
			cp0_rd_valid_ff <= cp0_rd_en;
		end
	end

	// configuration loader
	loader_state_t       state_ff;
	loader_state_t       nxt_state;
	logic [4:0]          idx_ff;
	logic                wait_ff;
	logic                pass_err_ff;
	logic [31:0]         cfg_mem_ff [NUM_WORDS];

	wire logic        reading    = (state_ff == LD_PRI) || (state_ff == LD_ALT);
	wire logic        issue      = reading && !wait_ff && !cfg_rd_req_ff;
	wire logic        take       = reading && wait_ff && cfg_rd_valid;
	wire logic        last_word  = (idx_ff == LAST_IDX);
	wire logic        pass_bad   = pass_err_ff || cfg_rd_ecc_err;
	wire logic [31:0] area_first = (state_ff == LD_ALT) ? `CFG_ALT_FIRST : `CFG_PRI_FIRST;  // [R12] [R13]
	wire logic [31:0] word_addr  = area_first + {25'h0, idx_ff, 2'h0};

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			LD_PRI: begin
				if (take && last_word) begin
					nxt_state = pass_bad ? LD_ALT : LD_DONE;  // [R10]
				end
			end
			LD_ALT: begin
				if (take && last_word) begin
					nxt_state = pass_bad ? LD_DEF : LD_DONE;  // [R11]
				end
			end
			LD_DEF:  nxt_state = LD_DONE;
			LD_DONE: nxt_state = LD_DONE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state_ff       <= LD_PRI;
			idx_ff         <= 5'h0;
			wait_ff        <= 1'b0;
			pass_err_ff    <= 1'b0;
			cfg_rd_req_ff  <= 1'b0;
			cfg_rd_addr_ff <= 32'h0;
		end else begin
			state_ff       <= nxt_state;
			cfg_rd_req_ff  <= issue;
			cfg_rd_addr_ff <= issue ? word_addr : cfg_rd_addr_ff;
			wait_ff        <= issue || (wait_ff && !take);
			if (take) begin
				idx_ff      <= last_word ? 5'h0 : idx_ff + 5'h1;
				pass_err_ff <= last_word ? 1'b0 : pass_bad;
			end
		end
	end

	// reset status flags, sticky until reset
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			reset_status_register_ff <= 32'h0;
		end else begin
			if (state_ff == LD_PRI && nxt_state == LD_ALT) begin
				reset_status_register_ff[`RSTAT_PRI_ERR_BIT] <= 1'b1;  // [R10]
			end
			if (state_ff == LD_ALT && nxt_state == LD_DEF) begin
				reset_status_register_ff[`RSTAT_FAIL_BIT] <= 1'b1;  // [R11]
			end
		end
	end

	// word storage; a later pass overwrites an earlier one
	for (genvar i = 0; i < NUM_WORDS; i++) begin : g_word
		wire logic wr = take && (idx_ff == 5'(i));
		always_ff @(posedge clk or negedge rst_sync_b) begin
			if (!rst_sync_b) begin
				cfg_mem_ff[i] <= `CFG_DEFAULT_WORD;
			end else if (state_ff == LD_DEF) begin
				cfg_mem_ff[i] <= `CFG_DEFAULT_WORD;  // [R11]
			end else if (wr) begin
				cfg_mem_ff[i] <= cfg_rd_data;  // [R10]
			end
		end
	end

	wire logic [31:0] sel_word = (cfg_word_idx <= LAST_IDX) ? cfg_mem_ff[cfg_word_idx] : 32'h0;

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cfg_word_ff       <= 32'h0;
			cpu_reset_hold_ff <= 1'b1;
		end else begin
			cfg_word_ff       <= sel_word;
			cpu_reset_hold_ff <= (nxt_state != LD_DONE);  // [R14]
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_b);

	property p_cfg5_nested;
		cp0_rd_en && cfg5_hit |=> cp0_rd_valid_ff && cp0_rd_data_ff[0];
	endproperty
	a_cfg5_nested: assert property (p_cfg5_nested) else $error("feature bit zero not one");  // [R1]

	property p_cfg5_upper;
		cp0_rd_valid_ff |-> cp0_rd_data_ff[31:1] == 31'h0;
	endproperty
	a_cfg5_upper: assert property (p_cfg5_upper) else $error("upper feature bits not zero");  // [R2]

	property p_seg_map;
		cpu_req && !error_level_flag_ff && cpu_addr[31:30] == 2'b10
			|=> cpu_paddr_ff == ($past(cpu_addr) & `SEG_OFFS_MASK);
	endproperty
	a_seg_map: assert property (p_seg_map) else $error("segment translation wrong");  // [R3] [R5]

	property p_boot_seg_a;
		cpu_req && !error_level_flag_ff && cpu_addr[31:29] == `SEG_A_TOP
			&& region_of(cpu_addr & `SEG_OFFS_MASK) inside {REG_BOOT, REG_SFR}
			|=> cpu_fault_ff;
	endproperty
	a_boot_seg_a: assert property (p_boot_seg_a) else $error("boot or sfr via first segment");  // [R4]

	property p_level_set;
		soft_reset || nmi |=> error_level_flag_ff;
	endproperty
	a_level_set: assert property (p_level_set) else $error("error level not set");  // [R6]

	property p_level_phys;
		cpu_req && error_level_flag_ff |=> cpu_paddr_ff == $past(cpu_addr);
	endproperty
	a_level_phys: assert property (p_level_phys) else $error("error level address translated");  // [R7]

	property p_dma_phys;
		dma_req |=> dma_ack_ff && dma_paddr_ff == $past(dma_addr);
	endproperty
	a_dma_phys: assert property (p_dma_phys) else $error("initiator address translated");  // [R8]

	property p_exec_ram;
		cpu_req && cpu_fetch && ram_exec_en && !error_level_flag_ff && cpu_addr[31:30] == 2'b10
			&& region_of(cpu_addr & `SEG_OFFS_MASK) == REG_RAM |=> !cpu_fault_ff;
	endproperty
	a_exec_ram: assert property (p_exec_ram) else $error("executable data ram fetch faulted");  // [R9]

	property p_pri_err;
		$rose(reset_status_register_ff[`RSTAT_PRI_ERR_BIT]) |-> state_ff == LD_ALT;
	endproperty
	a_pri_err: assert property (p_pri_err) else $error("primary flag without fallback");  // [R10]

	property p_fail;
		$rose(reset_status_register_ff[`RSTAT_FAIL_BIT])
			|-> state_ff == LD_DEF ##1 cfg_mem_ff[0] == `CFG_DEFAULT_WORD;
	endproperty
	a_fail: assert property (p_fail) else $error("failure flag without defaults");  // [R11]

	property p_pri_addr;
		cfg_rd_req_ff && state_ff == LD_PRI
			|-> cfg_rd_addr_ff >= `CFG_PRI_FIRST && cfg_rd_addr_ff <= `CFG_PRI_LAST;
	endproperty
	a_pri_addr: assert property (p_pri_addr) else $error("primary fetch out of range");  // [R12]

	property p_alt_addr;
		cfg_rd_req_ff && state_ff == LD_ALT
			|-> cfg_rd_addr_ff >= `CFG_ALT_FIRST && cfg_rd_addr_ff <= `CFG_ALT_LAST;
	endproperty
	a_alt_addr: assert property (p_alt_addr) else $error("alternate fetch out of range");  // [R13]

	property p_hold;
		!cpu_reset_hold_ff |-> state_ff == LD_DONE && !cfg_rd_req_ff;
	endproperty
	a_hold: assert property (p_hold) else $error("cpu released before selection");  // [R14]

	c_clean_boot: cover property ($fell(cpu_reset_hold_ff) && reset_status_register_ff == 32'h0);
	c_pri_err:    cover property ($rose(reset_status_register_ff[`RSTAT_PRI_ERR_BIT]));
	c_fail:       cover property ($rose(reset_status_register_ff[`RSTAT_FAIL_BIT]));
	c_seg_fault:  cover property (cpu_req && !error_level_flag_ff ##1 cpu_fault_ff);

endmodule : addr_map_top

/* File: tb/cfg_word_source.sv */
`timescale 1ns/1ns
`include "fixmap_defs.svh"

module cfg_word_source (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// bench control
	input  wire logic [1:0]  err_mode,
	input  wire logic [3:0]  slow,
	// word fetch
	input  wire logic        cfg_rd_req_ff,
	input  wire logic [31:0] cfg_rd_addr_ff,
	output logic             cfg_rd_valid,
	output logic [31:0]      cfg_rd_data,
	output logic             cfg_rd_ecc_err
);
	logic        pend_ff;
	logic [3:0]  wait_ff;
	logic [31:0] addr_ff;
	int          n_pri_ff;
	int          n_alt_ff;
	int          n_other_ff;
	wire logic   aligned = cfg_rd_addr_ff[1:0] == 2'h0;
	wire logic   in_pri  = aligned && cfg_rd_addr_ff >= `CFG_PRI_FIRST
		&& cfg_rd_addr_ff <= `CFG_PRI_LAST;
	wire logic   in_alt  = aligned && cfg_rd_addr_ff >= `CFG_ALT_FIRST
		&& cfg_rd_addr_ff <= `CFG_ALT_LAST;
	// one bad word in each area on demand
	wire logic   bad     = (err_mode != 2'h0 && addr_ff == `CFG_PRI_LAST)
		|| (err_mode == 2'h2 && addr_ff == `CFG_ALT_FIRST);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_ff        <= 1'b0;
			wait_ff        <= 4'h0;
			addr_ff        <= 32'h0;
			cfg_rd_valid   <= 1'b0;
			cfg_rd_ecc_err <= 1'b0;
			cfg_rd_data    <= 32'h0;
			n_pri_ff       <= 0;
			n_alt_ff       <= 0;
			n_other_ff     <= 0;
		end else begin
			cfg_rd_valid   <= 1'b0;
			cfg_rd_ecc_err <= 1'b0;
			// released data lines keep changing
			cfg_rd_data    <= ~cfg_rd_data;
			if (cfg_rd_req_ff) begin
				pend_ff    <= 1'b1;
				wait_ff    <= cfg_rd_addr_ff[2] ? slow : 4'h0;
				addr_ff    <= cfg_rd_addr_ff;
				n_pri_ff   <= n_pri_ff + int'(in_pri);
				n_alt_ff   <= n_alt_ff + int'(in_alt);
				n_other_ff <= n_other_ff + int'(!in_pri && !in_alt);
			end else if (pend_ff && wait_ff == 4'h0) begin
				pend_ff        <= 1'b0;
				cfg_rd_valid   <= 1'b1;
				cfg_rd_data    <= ~addr_ff;
				cfg_rd_ecc_err <= bad;
			end else if (pend_ff) begin
				wait_ff <= wait_ff - 4'h1;
			end
		end
	end
endmodule : cfg_word_source

/* File: tb/addr_map_top_tb.sv */
`timescale 1ns/1ns
`include "fixmap_defs.svh"

module addr_map_top_tb;
	import fixmap_pkg::*;
	logic clk = 1'b0, rst_b = 1'b0, cpu_req = 1'b0, cpu_fetch = 1'b0, soft_reset = 1'b0;
	logic nmi = 1'b0, error_level_clear = 1'b0, ram_exec_en = 1'b0;
	logic dma_req = 1'b0, cp0_rd_en = 1'b0;
	logic [31:0] cpu_addr = 32'h0, dma_addr = 32'h0;
	logic [4:0]  cp0_reg_num = 5'h0, cfg_word_idx = 5'h0;
	logic [2:0]  cp0_sel = 3'h0;
	logic [1:0]  err_mode = 2'h0;
	logic [3:0]  slow = 4'h0;
	logic [31:0] cpu_paddr_ff, dma_paddr_ff, cp0_rd_data_ff, cfg_rd_addr_ff, cfg_rd_data;
	logic [31:0] cfg_word_ff, reset_status_register_ff;
	region_t     cpu_region_ff, dma_region_ff;
	logic        cpu_fault_ff, cpu_ack_ff, error_level_flag_ff, cpu_reset_hold_ff;
	logic        dma_fault_ff, dma_ack_ff, cp0_rd_valid_ff, cfg_rd_req_ff;
	logic        cfg_rd_valid, cfg_rd_ecc_err;
	int          n_fail = 0;
	int          checks = 0;

	always #5 clk = ~clk;

	addr_map_top i_dut (.clk, .rst_b, .cpu_req, .cpu_fetch, .cpu_addr, .soft_reset, .nmi,
		.error_level_clear, .ram_exec_en, .cpu_paddr_ff, .cpu_region_ff,
		.cpu_fault_ff, .cpu_ack_ff,
		.error_level_flag_ff, .cpu_reset_hold_ff, .dma_req, .dma_addr, .dma_paddr_ff,
		.dma_region_ff, .dma_fault_ff, .dma_ack_ff, .cp0_rd_en, .cp0_reg_num, .cp0_sel,
		.cp0_rd_data_ff, .cp0_rd_valid_ff, .cfg_rd_req_ff, .cfg_rd_addr_ff, .cfg_rd_valid,
		.cfg_rd_data, .cfg_rd_ecc_err, .cfg_word_idx, .cfg_word_ff, .reset_status_register_ff);

	cfg_word_source i_src (.clk, .rst_b, .err_mode, .slow, .cfg_rd_req_ff, .cfg_rd_addr_ff,
		.cfg_rd_valid, .cfg_rd_data, .cfg_rd_ecc_err);

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic run_loader(input logic [1:0] mode, input logic [3:0] dly);
		int          k;
		logic [31:0] exp;
		err_mode = mode;
		slow     = dly;
		rst_b    = 1'b0;
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		cmp("error level after reset", 32'h1, error_level_flag_ff);
		for (k = 0; k < 4000 && cpu_reset_hold_ff === 1'b1; k++) @(negedge clk);
		if (k == 4000) begin
			n_fail++;
			$display("BAD loader_done expected 0 seen 1");
			give_verdict();
		end
		cmp("primary reads", 32'd27, i_src.n_pri_ff);
		cmp("alternate reads", mode != 2'h0 ? 32'd27 : 32'd0, i_src.n_alt_ff);
		cmp("stray reads", 32'd0, i_src.n_other_ff);
		exp = {4'h0, mode != 2'h0, mode == 2'h2, 26'h0};
		cmp("reset status", exp, reset_status_register_ff);
		for (k = 0; k < 28; k++) begin
			cfg_word_idx = 5'(k);
			@(negedge clk);
			exp = mode == 2'h0 ? ~(`CFG_PRI_FIRST + 32'(4 * k)) : ~(`CFG_ALT_FIRST + 32'(4 * k));
			exp = k == 27 ? 32'h0 : (mode == 2'h2 ? `CFG_DEFAULT_WORD : exp);
			cmp("config word", exp, cfg_word_ff);
		end
		$display("test loader mode %0d done", mode);
	endtask : run_loader

	task automatic acc(input logic dma, input logic f, input logic [31:0] a,
		input logic [31:0] pa, input region_t rg);
		@(negedge clk);
		{dma_req, cpu_req, cpu_fetch, cpu_addr, dma_addr} = {dma, !dma, f, a, a};
		@(negedge clk);
		{dma_req, cpu_req} = 2'b00;
		cmp("ack", 32'h1, dma ? dma_ack_ff : cpu_ack_ff);
		// a fetch from non-executable data ram faults but keeps its region
		cmp("fault", 32'(rg == REG_NONE || (f && !dma && rg == REG_RAM && !ram_exec_en)),
			dma ? dma_fault_ff : cpu_fault_ff);
		cmp("region", 32'(rg), dma ? dma_region_ff : cpu_region_ff);
		if (rg != REG_NONE) cmp("paddr", pa, dma ? dma_paddr_ff : cpu_paddr_ff);
	endtask : acc

	task automatic set_level(input logic sr, input logic nm, input logic clr, input logic exp);
		@(negedge clk);
		{soft_reset, nmi, error_level_clear} = {sr, nm, clr};
		@(negedge clk);
		{soft_reset, nmi, error_level_clear} = 3'b000;
		cmp("error level", 32'(exp), error_level_flag_ff);
	endtask : set_level

	task automatic t_map();
		set_level(1'b0, 1'b0, 1'b1, 1'b0);
		acc(1'b0, 1'b0, 32'h9d00_0010, 32'h1d00_0010, REG_PROG);
		acc(1'b0, 1'b0, 32'hbd03_fffc, 32'h1d03_fffc, REG_PROG);
		acc(1'b0, 1'b0, 32'h8000_0100, 32'h0000_0100, REG_RAM);
		acc(1'b0, 1'b0, 32'ha000_7fff, 32'h0000_7fff, REG_RAM);
		acc(1'b0, 1'b0, 32'ha000_8000, 32'h0, REG_NONE);
		acc(1'b0, 1'b0, 32'h9fc0_0000, 32'h0, REG_NONE);
		acc(1'b0, 1'b0, 32'h9f80_0000, 32'h0, REG_NONE);
		acc(1'b0, 1'b0, 32'hbfc0_17fc, 32'h1fc0_17fc, REG_BOOT);
		acc(1'b0, 1'b0, 32'hbf80_0010, 32'h1f80_0010, REG_SFR);
		acc(1'b0, 1'b0, 32'h1d00_0000, 32'h0, REG_NONE);
		acc(1'b0, 1'b1, 32'h8000_0040, 32'h0000_0040, REG_RAM);
		ram_exec_en = 1'b1;
		acc(1'b0, 1'b1, 32'ha000_0040, 32'h0000_0040, REG_RAM);
		ram_exec_en = 1'b0;
		$display("test mapping done");
	endtask : t_map

	task automatic t_level();
		set_level(1'b1, 1'b0, 1'b0, 1'b1);
		acc(1'b0, 1'b0, 32'h1d00_0020, 32'h1d00_0020, REG_PROG);
		acc(1'b0, 1'b0, 32'hbfc0_0000, 32'h0, REG_NONE);
		set_level(1'b0, 1'b0, 1'b1, 1'b0);
		set_level(1'b0, 1'b1, 1'b1, 1'b1);
		acc(1'b0, 1'b0, 32'h1f80_0004, 32'h1f80_0004, REG_SFR);
		set_level(1'b0, 1'b0, 1'b1, 1'b0);
		acc(1'b1, 1'b0, 32'h1fc0_0000, 32'h1fc0_0000, REG_BOOT);
		acc(1'b1, 1'b0, 32'h9d00_0000, 32'h0, REG_NONE);
		acc(1'b1, 1'b0, 32'h0000_7ffc, 32'h0000_7ffc, REG_RAM);
		$display("test error level done");
	endtask : t_level

	task automatic t_cp0();
		logic [4:0] rn [3] = '{5'h10, 5'h10, 5'h11};
		logic [2:0] sl [3] = '{3'h5, 3'h4, 3'h5};
		for (int k = 0; k < 3; k++) begin
			@(negedge clk);
			{cp0_rd_en, cp0_reg_num, cp0_sel} = {1'b1, rn[k], sl[k]};
			@(negedge clk);
			cp0_rd_en = 1'b0;
			cmp("cp0 valid", 32'h1, cp0_rd_valid_ff);
			cmp("cp0 data", k == 0 ? `CFG5_RESET : 32'h0, cp0_rd_data_ff);
		end
		$display("test feature register done");
	endtask : t_cp0

	initial begin
		@(negedge clk);
		run_loader(2'h2, 4'h0);
		rst_b = 1'b0;
		repeat (6) @(negedge clk);
		// release, then reset again 40 cycles later while the loader is busy
		rst_b = 1'b1;
		repeat (40) @(negedge clk);
		run_loader(2'h1, 4'h3);
		run_loader(2'h0, 4'h2);
		t_cp0();
		t_map();
		t_level();
		give_verdict();
	end
endmodule : addr_map_top_tb
